// ---- core/ltd_ctrl.sv ----
// tone gating, diagnostics and register file of the supply control block
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ltd_params.svh"
module ltd_ctrl #(
	parameter int SINK_CYC = `LTD_SINK_CYC
) (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// wishbone slave
	input  wire ltd_pkg::ltd_wb_req_t wb_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	// pins and analog conditions
	input  wire logic                tone_envelope_in_i,
	input  wire logic                tone_detect_in_i,
	input  wire ltd_pkg::ltd_cond_t   cond_i,
	output logic                     tone_out_o,
	output logic                     filter_bypass_out_o,
	output logic                     detected_data_out_o,
	output logic                     fault_n_o,
	output logic                     fault_n_oe_o,
	output logic [3:0]               out_level_o,
	output logic                     low_drop_mode_o,
	output logic                     level_boost_o
);
	import ltd_pkg::*;

	localparam logic [12:0] ON_CYC  = 13'(`LTD_ON_CYC);
	localparam logic [12:0] OFF_CYC = 13'(`LTD_OFF_CYC);
	localparam logic [12:0] HALF    = 13'(`LTD_TONE_HALF_CYC);
	localparam logic [23:0] SINK_N  = 24'(SINK_CYC);

	// saturating step shared by the request history counters
	function automatic logic [12:0] sat_inc(input logic [12:0] v);
		sat_inc = (v == 13'h1fff) ? v : v + 13'h0001;
	endfunction

	// pin synchronisers, first stage read only by second
	logic [1:0] env_s_ff, det_s_ff;
	logic [8:0] cnd_s1_ff, cnd_s2_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			env_s_ff  <= 2'b00;
			det_s_ff  <= 2'b00;
			cnd_s1_ff <= 9'h000;
			cnd_s2_ff <= 9'h000;
		end else begin
			env_s_ff  <= {env_s_ff[0], tone_envelope_in_i};
			det_s_ff  <= {det_s_ff[0], tone_detect_in_i};
			cnd_s1_ff <= cond_i;
			cnd_s2_ff <= cnd_s1_ff;
		end
	end
	logic      env, det;
	ltd_cond_t cnd;
	assign env = env_s_ff[1];
	assign det = det_s_ff[1];
	assign cnd = ltd_cond_t'(cnd_s2_ff);

	// bus decode
	logic lockout, acc, wr, rd_stat;
	assign lockout = ~cnd.supply_ok;
	assign acc     = wb_i.cyc & wb_i.stb & ~wb_ack_o & ~lockout;
	assign wr      = acc & wb_i.we & wb_i.sel[0];
	assign rd_stat = acc & ~wb_i.we &
		((wb_i.adr == `LTD_ADR_STAT1) | (wb_i.adr == `LTD_ADR_STAT2));

	// data registers
	logic [7:0] data1_ff, nxt_data1;
	logic [7:0] data4_ff, nxt_data4;
	always_comb begin
		nxt_data1 = data1_ff;
		nxt_data4 = data4_ff;
		if (lockout) begin
			nxt_data1 = `LTD_DATA_RST;
			nxt_data4 = `LTD_DATA_RST;
		end else if (wr && wb_i.adr == `LTD_ADR_DATA1) begin
			nxt_data1 = wb_i.dat[7:0];
		end else if (wr && wb_i.adr == `LTD_ADR_DATA4) begin
			nxt_data4 = wb_i.dat[7:0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data1_ff <= `LTD_DATA_RST;
			data4_ff <= `LTD_DATA_RST;
		end else begin
			data1_ff <= nxt_data1;
			data4_ff <= nxt_data4;
		end
	end
	logic tone_en, ext_waveform_sel, min_load_monitor_en;
	assign tone_en             = data1_ff[`LTD_TEN_POS];
	assign ext_waveform_sel    = data1_ff[`LTD_EXT_POS];
	assign min_load_monitor_en = data4_ff[`LTD_MON_POS];

	// level select, boosted when load monitor on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_level_o     <= 4'h0;
			low_drop_mode_o <= 1'b0;
			level_boost_o   <= 1'b0;
		end else begin
			out_level_o     <= min_load_monitor_en ? `LTD_LVL_MAX :
				data1_ff[`LTD_LVL_POS +: 4];
			level_boost_o   <= min_load_monitor_en;
			low_drop_mode_o <= data1_ff[`LTD_LDM_POS];
		end
	end

	// envelope gating state machine
	ltd_state_t st_ff, nxt_st;
	logic [12:0] dly_ff, nxt_dly;
	logic        gate_req;
	assign gate_req = tone_en & ~ext_waveform_sel & env;
	always_comb begin
		nxt_st  = st_ff;
		nxt_dly = dly_ff;
		case (st_ff)
			LTD_IDLE: begin
				nxt_dly = 13'h0000;
				if (gate_req) nxt_st = LTD_WAIT;
			end
			LTD_WAIT: begin
				nxt_dly = dly_ff + 13'h0001;
				if (!gate_req) nxt_st = LTD_IDLE;
				else if (dly_ff == ON_CYC - 13'h0002) nxt_st = LTD_TONE;
			end
			LTD_TONE: begin
				nxt_dly = 13'h0000;
				if (!gate_req) nxt_st = LTD_HOLD;
			end
			LTD_HOLD: begin
				nxt_dly = dly_ff + 13'h0001;
				if (gate_req) nxt_st = LTD_TONE;
				else if (dly_ff == OFF_CYC - 13'h0002) nxt_st = LTD_IDLE;
			end
			default: begin
				nxt_st  = LTD_IDLE;
				nxt_dly = 13'h0000;
			end
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff  <= LTD_IDLE;
			dly_ff <= 13'h0000;
		end else begin
			st_ff  <= nxt_st;
			dly_ff <= nxt_dly;
		end
	end
	logic tone_on;
	assign tone_on = (st_ff == LTD_TONE) || (st_ff == LTD_HOLD);

	// internal tone generator and output
	logic [12:0] ph_ff, nxt_ph;
	logic        sq_ff, nxt_sq;
	always_comb begin
		nxt_ph = (ph_ff == HALF - 13'h0001) ? 13'h0000 : ph_ff + 13'h0001;
		nxt_sq = (ph_ff == HALF - 13'h0001) ? ~sq_ff : sq_ff;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_ff               <= 13'h0000;
			sq_ff               <= 1'b0;
			tone_out_o          <= 1'b0;
			filter_bypass_out_o <= 1'b0;
		end else begin
			ph_ff               <= nxt_ph;
			sq_ff               <= nxt_sq;
			tone_out_o          <= tone_on & sq_ff;
			filter_bypass_out_o <= tone_on;
		end
	end

	// detected data follows detector activity
	always_ff @(posedge clk_i) begin
		if (rst_i) detected_data_out_o <= 1'b0;
		else       detected_data_out_o <= det;
	end

	// sink overcurrent timeout
	logic [23:0] sink_ff, nxt_sink;
	always_comb begin
		nxt_sink = 24'h000000;
		if (cnd.sink_oc && sink_ff != SINK_N) nxt_sink = sink_ff + 24'h000001;
		else if (cnd.sink_oc) nxt_sink = sink_ff;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) sink_ff <= 24'h000000;
		else       sink_ff <= nxt_sink;
	end

	// latched fault flags, set wins over read clear
	logic [2:0] lat_ff, nxt_lat;
	logic [2:0] cause;
	logic       rd_stat_ff;
	assign cause = {cnd.supply_low, cnd.overtemp, cnd.overload};
	always_comb begin
		nxt_lat = lat_ff;
		if (wb_ack_o && rd_stat_ff)
			nxt_lat = lat_ff & cause;
		nxt_lat = nxt_lat | cause;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lat_ff     <= 3'b000;
			rd_stat_ff <= 1'b0;
		end else begin
			lat_ff     <= nxt_lat;
			rd_stat_ff <= rd_stat;
		end
	end

	// open drain fault pin
	assign fault_n_o    = 1'b0;
	assign fault_n_oe_o = |lat_ff;

	// status words
	logic [7:0] stat1, stat2;
	assign stat1 = {4'h0, cnd.level_low & (out_level_o != 4'h0), lat_ff};
	assign stat2 = {3'h0, (sink_ff == SINK_N),
		min_load_monitor_en & cnd.load_low,
		cnd.tone_seen, cnd.tone_bad, 1'b0};

	// wishbone answer, one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= acc;
			if (acc && !wb_i.we) begin
				case (wb_i.adr)
					`LTD_ADR_DATA1: wb_dat_o <= {24'h000000, data1_ff};
					`LTD_ADR_DATA4: wb_dat_o <= {24'h000000, data4_ff};
					`LTD_ADR_STAT1: wb_dat_o <= {24'h000000, stat1};
					`LTD_ADR_STAT2: wb_dat_o <= {24'h000000, stat2};
					default:        wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// check helpers: edges in a row with and without a gate request
	logic [12:0] gate_run_ff, nxt_gate_run;
	logic [12:0] gate_idle_ff, nxt_gate_idle;
	always_comb begin
		nxt_gate_run  = 13'h0000;
		nxt_gate_idle = 13'h0000;
		if (gate_req) begin
			nxt_gate_run = sat_inc(gate_run_ff);
		end else begin
			nxt_gate_idle = sat_inc(gate_idle_ff);
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_run_ff  <= 13'h0000;
			gate_idle_ff <= 13'h0000;
		end else begin
			gate_run_ff  <= nxt_gate_run;
			gate_idle_ff <= nxt_gate_idle;
		end
	end

	// checks: tone start and stop against the request history, then fault pin, flags, lockout, level and bus answer
	tone_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(tone_on) |-> (gate_run_ff == ON_CYC))
		else $error("tone start delay wrong");
	tone_late_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(gate_run_ff >= ON_CYC) |-> tone_on)
		else $error("tone missing under envelope");
	tone_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(tone_on) |-> (gate_idle_ff == OFF_CYC))
		else $error("tone stop delay wrong");
	tone_cease_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(gate_idle_ff >= OFF_CYC) |-> !tone_on)
		else $error("tone held after envelope");
	bypass_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 (filter_bypass_out_o == $past(tone_on)))
		else $error("bypass not following tone");
	tone_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tone_out_o |-> $past(tone_on))
		else $error("tone without gate");
	fault_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(|lat_ff) |-> (fault_n_oe_o && !fault_n_o))
		else $error("fault pin not low");
	flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(lat_ff[0] && !(wb_ack_o && rd_stat_ff)) |=> lat_ff[0])
		else $error("latched flag dropped without read");
	lock_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lockout |=> (data1_ff == 8'h00 && data4_ff == 8'h00))
		else $error("data not zero in lockout");
	boost_lvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
		min_load_monitor_en |=> (out_level_o == `LTD_LVL_MAX))
		else $error("boost level missing");
	power_bad_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cnd.supply_low |=> lat_ff[2])
		else $error("power bad flag not set");
	ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	ack_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
		acc |=> wb_ack_o)
		else $error("ack not one cycle after request");
	lock_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lockout |=> !wb_ack_o)
		else $error("bus answered in lockout");
	data_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_i.adr == `LTD_ADR_DATA1) |=> (data1_ff == $past(wb_i.dat[7:0])))
		else $error("level write lost");
	level_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!min_load_monitor_en |=> (out_level_o == $past(data1_ff[`LTD_LVL_POS +: 4])))
		else $error("level not following select field");

	// checks: fault flags, pin, live status and detected data
	fault_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(fault_n_oe_o && !(wb_ack_o && rd_stat_ff)) |=> fault_n_oe_o)
		else $error("fault pin released without read");
	flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(lat_ff[1] && !cause[1] && wb_ack_o && rd_stat_ff) |=> !lat_ff[1])
		else $error("latched flag kept after read");
	sink_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!cnd.sink_oc |=> (sink_ff == 24'h000000))
		else $error("sink timer kept without overcurrent");
	det_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		detected_data_out_o == $past(tone_detect_in_i, 3))
		else $error("detected data not following pin");

	// covers for the main scenarios
	tone_run_c: cover property (@(posedge clk_i) disable iff (rst_i) st_ff == LTD_HOLD);
	fault_clr_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(lat_ff[0]));
	sink_to_c: cover property (@(posedge clk_i) disable iff (rst_i) sink_ff == SINK_N);
	tone_rise_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(tone_on));
	stat_read_c: cover property (@(posedge clk_i) disable iff (rst_i) wb_ack_o && rd_stat_ff);
endmodule : ltd_ctrl
`default_nettype wire

// ---- core/ltd_params.svh ----
// constants for the tone and diagnostic control block
`ifndef LTD_PARAMS_SVH
`define LTD_PARAMS_SVH
`define LTD_CLK_MHZ       250
`define LTD_ON_DLY_NS     6000
`define LTD_OFF_DLY_NS    30000
`define LTD_ON_CYC        ((`LTD_ON_DLY_NS * `LTD_CLK_MHZ + 999) / 1000)
`define LTD_OFF_CYC       ((`LTD_OFF_DLY_NS * `LTD_CLK_MHZ) / 1000)
`define LTD_SINK_TO_US    10000
`define LTD_SINK_CYC      ((`LTD_SINK_TO_US * `LTD_CLK_MHZ))
`define LTD_TONE_HALF_CYC 5682
`define LTD_ADR_DATA1     4'h0
`define LTD_ADR_DATA4     4'h4
`define LTD_ADR_STAT1     4'h8
`define LTD_ADR_STAT2     4'hc
`define LTD_LVL_POS       0
`define LTD_TEN_POS       4
`define LTD_EXT_POS       5
`define LTD_LDM_POS       6
`define LTD_MON_POS       0
`define LTD_LVL_MAX       4'hf
`define LTD_DATA_RST      8'h00
`endif

// ---- core/ltd_pkg.sv ----
// types for the tone and diagnostic control block
package ltd_pkg;
	// wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ltd_wb_req_t;
	// analog condition indications
	typedef struct packed {
		logic overload;
		logic overtemp;
		logic supply_low;
		logic supply_ok;
		logic level_low;
		logic tone_bad;
		logic tone_seen;
		logic load_low;
		logic sink_oc;
	} ltd_cond_t;
	typedef enum logic [1:0] {
		LTD_IDLE = 2'b00,
		LTD_WAIT = 2'b01,
		LTD_TONE = 2'b10,
		LTD_HOLD = 2'b11
	} ltd_state_t;
endpackage : ltd_pkg

// ---- tb/ltd_host.sv ----
// bus master model standing in for the host processor
`timescale 1ns/100ps
`default_nettype none
module ltd_host (
	// clock and bus answer
	input  wire logic            clk_i,
	input  wire logic            ack_i,
	// bus request
	output ltd_pkg::ltd_wb_req_t req_o
);
	import ltd_pkg::*;
	// idle bus from time zero
	initial req_o = '0;
	// one classic cycle on byte lane 0, held until ack is sampled
	task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		req_o <= '0;
	endtask
endmodule // ltd_host
`default_nettype wire

// ---- tb/ltd_ctrl_test.sv ----
// self-checking bench for the tone and diagnostic control block
`timescale 1ns/100ps
`default_nettype none
module ltd_ctrl_test;
	import ltd_pkg::*;
	logic        clk_i, rst_i, env, det, t0;
	ltd_wb_req_t wb_i;
	ltd_cond_t   cond;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, tone_o, byp_o, data_o, flt_n, flt_oe, ldm_o, boost_o;
	logic [3:0]  lvl_o, lvl;
	logic [7:0]  exp_q[$];
	int          fail_count, checked, n, tgl;
	// open-drain fault pin with its pull-up
	wire logic   flt_pin = flt_oe ? flt_n : 1'b1;

	ltd_ctrl #(.SINK_CYC(50)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.tone_envelope_in_i(env), .tone_detect_in_i(det), .cond_i(cond), .tone_out_o(tone_o),
		.filter_bypass_out_o(byp_o), .detected_data_out_o(data_o), .fault_n_o(flt_n),
		.fault_n_oe_o(flt_oe), .out_level_o(lvl_o), .low_drop_mode_o(ldm_o),
		.level_boost_o(boost_o)
	);
	ltd_host u_host (.clk_i(clk_i), .ack_i(wb_ack_o), .req_o(wb_i));

	// 250 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// watchdog well beyond the expected run
	initial begin
		#200000;
		fail_count++;
		stop_test();
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.xfer(1'b0, a, 8'h00);
	endtask
	// apply a condition word, let it settle, then read one status register
	task automatic stim(input logic [8:0] c, input logic [3:0] a, input logic [7:0] e);
		cond <= ltd_cond_t'(c);
		repeat (60) @(posedge clk_i);
		rd(a, e);
	endtask

	// read watcher: oldest expected value against data at each read ack
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_i.we === 1'b0) begin
			check("rdata", wb_dat_o, {24'h0, exp_q.pop_front()});
		end
	end

	initial begin
		rst_i = 1'b1;
		env = 1'b0;
		det = 1'b0;
		cond = '0;
		void'($urandom(32'hfeda));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		// lockout after reset keeps everything off
		repeat (4) @(posedge clk_i);
		check("lvl_lock", lvl_o, 4'h0);
		check("flt_idle", flt_pin, 1'b1);
		cond <= ltd_cond_t'(9'h020);
		repeat (4) @(posedge clk_i);
		// level select, readback, unmapped place
		lvl = 4'($urandom_range(14, 1));
		wr(4'h0, {4'h4, lvl});
		rd(4'h0, {4'h4, lvl});
		rd(4'h2, 8'h00);
		check("lvl", lvl_o, lvl);
		check("ldm", ldm_o, 1'b1);
		// supply drop clears the data registers
		cond <= '0;
		repeat (6) @(posedge clk_i);
		check("lvl_uv", lvl_o, 4'h0);
		cond <= ltd_cond_t'(9'h020);
		repeat (4) @(posedge clk_i);
		rd(4'h0, 8'h00);
		wr(4'h0, {4'h1, lvl});
		repeat (2) @(posedge clk_i);
		check("lvl_back", lvl_o, lvl);
		// envelope-driven tone start and stop delays
		env <= 1'b1;
		for (n = 0; n < 2000 && byp_o !== 1'b1; n++) @(posedge clk_i);
		check("on_dly", n >= 1490 && n <= 1520, 1'b1);
		// two tone half periods hold exactly two output changes
		t0 = tone_o;
		tgl = 0;
		repeat (11364) begin
			@(posedge clk_i);
			if (tone_o !== t0) tgl++;
			t0 = tone_o;
		end
		check("tone_run", tgl, 2);
		env <= 1'b0;
		for (n = 0; n < 16000 && byp_o !== 1'b0; n++) @(posedge clk_i);
		check("off_dly", n >= 3750 && n <= 15000, 1'b1);
		// external waveform selected, then tone enable cleared: no envelope tone
		for (int k = 0; k < 2; k++) begin
			wr(4'h0, {k == 0 ? 4'h3 : 4'h0, lvl});
			env <= 1'b1;
			repeat (2000) @(posedge clk_i);
			check("gated", byp_o, 1'b0);
			env <= 1'b0;
			repeat (8) @(posedge clk_i);
		end
		// detector data follows the pin
		repeat (8) begin
			t0 = 1'($urandom);
			det <= t0;
			repeat (6) @(posedge clk_i);
			check("det", data_o, t0);
		end
		// latched faults: overload, overtemp, power bad
		for (int k = 0; k < 3; k++) begin
			stim(9'h020 | (9'h100 >> k), 4'h8, 8'h01 << k);
			check("flt_on", flt_pin, 1'b0);
			cond <= ltd_cond_t'(9'h020);
			repeat (60) @(posedge clk_i);
			check("flt_hold", flt_pin, 1'b0);
			rd(4'h8, 8'h01 << k);
			rd(4'h8, 8'h00);
			check("flt_off", flt_pin, 1'b1);
		end
		// live flags; min load only while its monitor is on
		stim(9'h022, 4'hc, 8'h00);
		wr(4'h4, 8'h01);
		repeat (2) @(posedge clk_i);
		check("boost", {boost_o, lvl_o}, 5'h1f);
		for (int k = 0; k < 5; k++) begin
			stim(9'h020 | (9'h010 >> k), k == 0 ? 4'h8 : 4'hc, k == 0 ? 8'h08 : 8'h01 << k);
		end
		// output and monitor off: no level or load fault reported
		wr(4'h4, 8'h00);
		wr(4'h0, 8'h00);
		stim(9'h032, 4'h8, 8'h00);
		rd(4'hc, 8'h00);
		stim(9'h020, 4'hc, 8'h00);
		rd(4'h8, 8'h00);
		repeat (4) @(posedge clk_i);
		stop_test();
	end
endmodule // ltd_ctrl_test
`default_nettype wire
